// ### design/e1s_pkg.sv
// Purpose: Shared constants for the E1 receive status word block
// Assumes: 100 MHz system clock, 32-slot serial control stream
// Notes: Times are kept in their own units; cycle counts derive from them
package e1s_pkg;
	// System clock
	localparam int unsigned CLK_HZ = 100_000_000;

	// Control stream channels that carry the status words
	localparam logic [4:0] CH_NON_ALIGN = 5'h11;
	localparam logic [4:0] CH_MASTER_ONE = 5'h12;
	localparam logic [4:0] CH_PHASE = 5'h13;
	localparam logic [4:0] CH_CRC_COUNT = 5'h14;

	// Master status word one field positions
	localparam int unsigned MS1_FRAME_LOST = 7;
	localparam int unsigned MS1_MFRAME_LOST = 6;
	localparam int unsigned MS1_FAS_ERR = 5;
	localparam int unsigned MS1_SLIP = 4;
	localparam int unsigned MS1_RX_AIS = 3;
	localparam int unsigned MS1_TS16_AIS = 2;
	localparam int unsigned MS1_EXT_SENSE = 1;

	// Values after reset
	localparam logic [7:0] NON_ALIGN_RST = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_MAX = 8'hFF;
	localparam logic SERIAL_IDLE = 1'b1;

	// Frame alignment error threshold
	localparam logic [4:0] FAS_ERR_LIMIT = 5'h10;

	// Least spacing between two alignment error toggles
	localparam int unsigned FAS_HOLDOFF_MS = 128;
	localparam int unsigned FAS_HOLDOFF_CYC = FAS_HOLDOFF_MS * (CLK_HZ / 1000);

	// CRC accumulation interval
	localparam int unsigned CRC_INTERVAL_S = 1;
	localparam int unsigned CRC_INTERVAL_CYC = CRC_INTERVAL_S * CLK_HZ;
endpackage : e1s_pkg

// ### design/e1s_status_words.sv
// Purpose: Builds the four receive status words, shifts them on channels 17-20
// Assumes: Framer delivers event pulses and levels synchronous to CLK_I
// Notes: Control stream bit timing comes from BIT_STROBE_I and FRAME_PULSE_I
//
// Summary of operation
// - Channel 17 bit 7 carries received NFAS timeslot-0 bit 1.
// - Channel 17 bit 6 carries received NFAS marker bit, expected one.
// - Channel 17 bit 5 carries remote alarm bit from NFAS frames.
// - Channel 17 bits 4-0 carry national bits 4 to 8.
// - Channel 18 bit 7 set on frame lock loss, cleared on lock.
// - Channel 18 bit 6 set on multiframe lock loss, cleared on lock.
// - Channel 18 bit 5 toggles after sixteen or more alignment errors.
// - Alignment error toggle changes at most once per 128 ms.
// - Channel 18 bit 4 toggles on every receive slip.
// - Channel 18 bit 3 follows line all-ones alarm detection.
// - Channel 18 bit 2 follows timeslot 16 all-ones alarm detection.
// - Channel 18 bit 1 samples external sense once per frame; bit 0 zero.
// - Channel 19 bits 7-3 hold slot count at transmit marker rise.
// - Channel 19 bits 2-0 hold bit position within that slot.
// - Channel 20 is eight-bit CRC error counter wrapping after FF.
// - With maintenance on, CRC counter clears each one-second interval end.
// - Frame count bit extends phase word as ninth bit on wrap.
module e1s_status_words #(
	parameter int unsigned HOLDOFF_CYC = e1s_pkg::FAS_HOLDOFF_CYC,
	parameter int unsigned INTERVAL_CYC = e1s_pkg::CRC_INTERVAL_CYC
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic BIT_STROBE_I,
	input wire logic FRAME_PULSE_I,
	input wire logic NFAS_VALID_I,
	input wire logic [7:0] NFAS_BYTE_I,
	input wire logic FRAME_LOCK_LOST_I,
	input wire logic MULTIFRAME_LOCK_LOST_I,
	input wire logic FAS_ERROR_I,
	input wire logic SLIP_I,
	input wire logic RX_ALL_ONES_ALARM_I,
	input wire logic RX_SIGNALLING_SLOT_ALL_ONES_I,
	input wire logic EXT_SENSE_I,
	input wire logic TRANSMIT_8KHZ_MARKER_I,
	input wire logic CRC_ERROR_I,
	input wire logic MAINT_I,
	output logic CONTROL_SERIAL_OUT_O,
	output logic CONTROL_SERIAL_EN_O,
	output logic FRAME_COUNT_MSB_O
);
	logic [4:0] slot_reg;
	logic [2:0] bit_reg;
	logic [4:0] slot_next;
	logic [2:0] bit_next;
	logic [7:0] non_align_reg;
	logic [7:0] master_one_reg;
	logic [7:0] phase_reg;
	logic [7:0] crc_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] sel_word;
	logic sel_hit;
	logic [4:0] fas_cnt_reg;
	logic [31:0] holdoff_reg;
	logic holdoff_done;
	logic fas_toggle;
	logic [31:0] sec_reg;
	logic sec_end;
	logic marker_reg;
	logic marker_rise;
	logic [7:0] phase_now;
	logic ser_out_reg;
	logic ser_en_reg;
	logic fcnt_reg;

	// Next stream position; frame pulse restarts at slot 0 bit 0
	always_comb begin
		if (FRAME_PULSE_I) begin
			slot_next = '0;
			bit_next = '0;
		end else begin
			slot_next = (bit_reg == 3'h7) ? 5'(slot_reg + 5'h01) : slot_reg;
			bit_next = 3'(bit_reg + 3'h1);
		end
	end

	// Stream position counters
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			slot_reg <= '0;
			bit_reg <= '0;
		end else if (BIT_STROBE_I) begin
			slot_reg <= slot_next;
			bit_reg <= bit_next;
		end
	end

	// Word owned by the channel about to start
	always_comb begin
		sel_hit = 1'b1;
		unique case (slot_next)
			e1s_pkg::CH_NON_ALIGN: sel_word = non_align_reg;
			e1s_pkg::CH_MASTER_ONE: sel_word = master_one_reg;
			e1s_pkg::CH_PHASE: sel_word = phase_reg;
			e1s_pkg::CH_CRC_COUNT: sel_word = crc_cnt_reg;
			default: begin
				sel_word = e1s_pkg::BYTE_MAX;
				sel_hit = 1'b0;
			end
		endcase
	end

	// Serializer; whole byte latched at bit 0 so a word never tears mid-channel
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			shift_reg <= e1s_pkg::BYTE_MAX;
			ser_out_reg <= e1s_pkg::SERIAL_IDLE;
			ser_en_reg <= 1'b0;
		end else if (BIT_STROBE_I) begin
			if (bit_next == 3'h0) begin
				ser_out_reg <= sel_word[7];
				shift_reg <= {sel_word[6:0], 1'b1};
				ser_en_reg <= sel_hit;
			end else begin
				ser_out_reg <= shift_reg[7];
				shift_reg <= {shift_reg[6:0], 1'b1};
			end
		end
	end

	// Received non-alignment byte, stored whole as it arrives
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			non_align_reg <= e1s_pkg::NON_ALIGN_RST;
		end else if (NFAS_VALID_I) begin
			non_align_reg[7] <= NFAS_BYTE_I[7];
			non_align_reg[6] <= NFAS_BYTE_I[6];
			non_align_reg[5] <= NFAS_BYTE_I[5];
			non_align_reg[4:0] <= NFAS_BYTE_I[4:0];
		end
	end

	// Alignment error counting; count saturates so an early burst is not lost
	assign holdoff_done = (holdoff_reg >= 32'(HOLDOFF_CYC - 1));
	assign fas_toggle = (fas_cnt_reg >= e1s_pkg::FAS_ERR_LIMIT) && holdoff_done;
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			fas_cnt_reg <= '0;
			holdoff_reg <= '0;
		end else begin
			if (fas_toggle) begin
				fas_cnt_reg <= FAS_ERROR_I ? 5'h01 : 5'h00;
				holdoff_reg <= '0;
			end else begin
				if (FAS_ERROR_I && fas_cnt_reg < e1s_pkg::FAS_ERR_LIMIT) begin
					fas_cnt_reg <= 5'(fas_cnt_reg + 5'h01);
				end
				if (!holdoff_done) begin
					holdoff_reg <= 32'(holdoff_reg + 32'h1);
				end
			end
		end
	end

	// Master status word one
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			master_one_reg <= e1s_pkg::BYTE_ZERO;
		end else begin
			master_one_reg[e1s_pkg::MS1_FRAME_LOST] <= FRAME_LOCK_LOST_I;
			master_one_reg[e1s_pkg::MS1_MFRAME_LOST] <= MULTIFRAME_LOCK_LOST_I;
			if (fas_toggle) begin
				master_one_reg[e1s_pkg::MS1_FAS_ERR] <= ~master_one_reg[e1s_pkg::MS1_FAS_ERR];
			end
			if (SLIP_I) begin
				master_one_reg[e1s_pkg::MS1_SLIP] <= ~master_one_reg[e1s_pkg::MS1_SLIP];
			end
			master_one_reg[e1s_pkg::MS1_RX_AIS] <= RX_ALL_ONES_ALARM_I;
			master_one_reg[e1s_pkg::MS1_TS16_AIS] <= RX_SIGNALLING_SLOT_ALL_ONES_I;
			if (BIT_STROBE_I && FRAME_PULSE_I) begin
				master_one_reg[e1s_pkg::MS1_EXT_SENSE] <= EXT_SENSE_I;
			end
			master_one_reg[0] <= 1'b0;
		end
	end

	// Transmit phase capture on marker rising edge
	assign marker_rise = TRANSMIT_8KHZ_MARKER_I && !marker_reg;
	assign phase_now = {slot_reg, bit_reg};
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			marker_reg <= 1'b0;
			phase_reg <= e1s_pkg::BYTE_ZERO;
			fcnt_reg <= 1'b0;
		end else begin
			marker_reg <= TRANSMIT_8KHZ_MARKER_I;
			if (marker_rise) begin
				phase_reg <= phase_now;
				// Wrap across slot 31 bit 7 either way flips the ninth bit
				if ((phase_reg[7:6] == 2'h3 && phase_now[7:6] == 2'h0) ||
					(phase_reg[7:6] == 2'h0 && phase_now[7:6] == 2'h3)) begin
					fcnt_reg <= ~fcnt_reg;
				end
			end
		end
	end

	// One-second accumulation timer, free running
	assign sec_end = (sec_reg == 32'(INTERVAL_CYC - 1));
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sec_reg <= '0;
		end else begin
			sec_reg <= sec_end ? 32'h0 : 32'(sec_reg + 32'h1);
		end
	end

	// CRC error counter; an error in the clearing cycle still counts
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			crc_cnt_reg <= e1s_pkg::BYTE_ZERO;
		end else if (MAINT_I && sec_end) begin
			crc_cnt_reg <= CRC_ERROR_I ? 8'h01 : 8'h00;
		end else if (CRC_ERROR_I) begin
			crc_cnt_reg <= 8'(crc_cnt_reg + 8'h01);
		end
	end

	assign CONTROL_SERIAL_OUT_O = ser_out_reg;
	assign CONTROL_SERIAL_EN_O = ser_en_reg;
	assign FRAME_COUNT_MSB_O = fcnt_reg;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);

	// Channel 17 starts: first bit out is bit 7, with the enable set
	sequence s_ch17_start;
		BIT_STROBE_I && slot_next == e1s_pkg::CH_NON_ALIGN && bit_next == 3'h0;
	endsequence
	sequence s_first_bits;
		ser_out_reg == $past(non_align_reg[7]) && ser_en_reg;
	endsequence

	// Stream framing and serial output
	chk_msb_first_out: assert property (
		s_ch17_start |=> s_first_bits)
		else $error("Channel 17 did not start with bit 7");
	chk_idle_stream: assert property (
		!ser_en_reg |-> ser_out_reg)
		else $error("Serial output not idle outside status channels");
	chk_stream_position: assert property (
		BIT_STROBE_I && FRAME_PULSE_I |=> slot_reg == 5'h00 && bit_reg == 3'h0)
		else $error("Frame pulse did not restart stream position");

	// Captured words and status flags
	chk_nfas_byte_capture: assert property (
		NFAS_VALID_I |=> non_align_reg == $past(NFAS_BYTE_I))
		else $error("Non-alignment byte not captured");
	chk_frame_lock_flag: assert property (
		##1 master_one_reg[7] == $past(FRAME_LOCK_LOST_I))
		else $error("Frame lock flag does not follow input");
	chk_mframe_lock_flag: assert property (
		$rose(MULTIFRAME_LOCK_LOST_I) |=> master_one_reg[6])
		else $error("Multiframe lock flag not set");
	chk_mframe_lock_clear: assert property (
		!MULTIFRAME_LOCK_LOST_I |=> !master_one_reg[6])
		else $error("Multiframe lock flag not cleared");
	chk_line_ais_flag: assert property (
		RX_ALL_ONES_ALARM_I ##1 RX_ALL_ONES_ALARM_I |-> master_one_reg[3])
		else $error("Line alarm flag missing");
	chk_ts16_ais_flag: assert property (
		!RX_SIGNALLING_SLOT_ALL_ONES_I |=> !master_one_reg[2])
		else $error("Slot 16 alarm flag stuck");
	chk_ext_sense_sample: assert property (
		BIT_STROBE_I && FRAME_PULSE_I
		|=> master_one_reg[1] == $past(EXT_SENSE_I) && !master_one_reg[0])
		else $error("External sense not sampled");

	// Toggle bits; alignment toggle spaced by the hold-off
	chk_fas_err_count: assert property (
		$changed(master_one_reg[5]) |-> $past(fas_cnt_reg) >= 5'h10)
		else $error("Alignment toggle without sixteen errors");
	chk_fas_err_spacing: assert property (
		$changed(master_one_reg[5]) |-> $past(holdoff_done) && holdoff_reg == 0)
		else $error("Alignment toggle inside hold-off");
	chk_fas_err_hold: assert property (
		!fas_toggle |=> $stable(master_one_reg[5]))
		else $error("Alignment toggle changed without a toggle event");
	chk_slip_toggle_bit: assert property (
		SLIP_I |=> master_one_reg[4] != $past(master_one_reg[4]))
		else $error("Slip did not toggle status");

	// Phase capture and CRC counter
	chk_phase_capture: assert property (
		marker_rise |=> phase_reg == {$past(slot_reg), $past(bit_reg)})
		else $error("Phase word not captured");
	chk_ninth_bit_wrap: assert property (
		marker_rise && phase_reg[7:6] == 2'h3 && phase_now[7:6] == 2'h0
		|=> fcnt_reg != $past(fcnt_reg))
		else $error("Ninth phase bit did not flip on wrap");
	chk_ninth_bit_hold: assert property (
		!marker_rise |=> $stable(fcnt_reg))
		else $error("Ninth phase bit changed without capture");
	chk_crc_wrap_count: assert property (
		CRC_ERROR_I && !(MAINT_I && sec_end) |=> crc_cnt_reg == 8'($past(crc_cnt_reg) + 8'h01))
		else $error("CRC counter did not step");
	chk_crc_interval_clr: assert property (
		MAINT_I && sec_end && !CRC_ERROR_I |=> crc_cnt_reg == 8'h00)
		else $error("CRC counter not cleared at interval end");
endmodule // e1s_status_words

// ### tb/e1s_host_model.sv
// Purpose: Host side of the control stream: makes bit timing, collects words
// Assumes: One bit every four clocks, 256 bits per frame
// Notes: word_o 0..3 hold channels 17..20 of the last whole frame
module e1s_host_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic sdata_i,
	input wire logic sen_i,
	output logic strobe_o,
	output logic frame_o,
	output logic [7:0] pos_o,
	output logic [7:0] word_o [4],
	output int frames_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_reg;
	logic [4:0] nbit_reg;
	logic [6:0] sh_reg;
	// Fast bit rate keeps the run short; spacing still leaves quiet cycles
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_reg <= 2'h0;
			pos_o <= 8'hFF;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (strobe_o) pos_o <= pos_o + 8'h01;
		end
	end
	assign strobe_o = (div_reg == 2'h3);
	assign frame_o = strobe_o && (pos_o == 8'hFF);
	// Sampled at the next strobe, where the previous bit still stands
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			nbit_reg <= 5'h00;
			sh_reg <= 7'h00;
			frames_o <= 0;
		end else if (strobe_o) begin
			if (sen_i) begin
				sh_reg <= {sh_reg[5:0], sdata_i};
				nbit_reg <= nbit_reg + 5'h01;
				if (nbit_reg[2:0] == 3'h7) word_o[nbit_reg[4:3]] <= {sh_reg, sdata_i};
				if (nbit_reg == 5'h1F) frames_o <= frames_o + 1;
			end else begin
				nbit_reg <= 5'h00;
			end
		end
	end
endmodule // e1s_host_model

// ### tb/e1s_status_words_tb.sv
// Purpose: Self-checking bench for the receive status words
// Assumes: Short hold-off and interval counts so waits stay small
// Notes: Every word check reads a whole fresh frame through the host model
module e1s_status_words_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, nv = 1'b0, fll = 1'b0, mll = 1'b0, fe = 1'b0, sl = 1'b0;
	logic remote_alarm = 1'b0, ts16 = 1'b0, ext = 1'b0, mk = 1'b0, ce = 1'b0, mt = 1'b0;
	logic [7:0] nb = 8'h00;
	logic so, sen, fmsb, stb, fp;
	logic [7:0] pos;
	logic [7:0] w [4];
	int frames, fails = 0, tests_run = 0;
	always #5 clk = ~clk;
	e1s_status_words #(.HOLDOFF_CYC(3000), .INTERVAL_CYC(4096)) i_e1s_status_words (
		.CLK_I(clk), .RSTN_I(rstn), .BIT_STROBE_I(stb), .FRAME_PULSE_I(fp),
		.NFAS_VALID_I(nv), .NFAS_BYTE_I(nb), .FRAME_LOCK_LOST_I(fll),
		.MULTIFRAME_LOCK_LOST_I(mll), .FAS_ERROR_I(fe), .SLIP_I(sl),
		.RX_ALL_ONES_ALARM_I(remote_alarm), .RX_SIGNALLING_SLOT_ALL_ONES_I(ts16), .EXT_SENSE_I(ext),
		.TRANSMIT_8KHZ_MARKER_I(mk), .CRC_ERROR_I(ce), .MAINT_I(mt),
		.CONTROL_SERIAL_OUT_O(so), .CONTROL_SERIAL_EN_O(sen), .FRAME_COUNT_MSB_O(fmsb));
	e1s_host_model i_e1s_host_model (.clk_i(clk), .rstn_i(rstn), .sdata_i(so), .sen_i(sen),
		.strobe_o(stb), .frame_o(fp), .pos_o(pos), .word_o(w), .frames_o(frames));
	// Verdict in one place
	task automatic final_report;
		if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Two frame ends, so the last frame started after any update
	task automatic check_words(input logic [7:0] a, b, c, d);
		int f0;
		int i;
		f0 = frames;
		for (i = 0; i < 3000 && frames < f0 + 2; i++) @(posedge clk);
		if (frames < f0 + 2) begin
			fails++;
			final_report();
		end
		check8("ch17", a, w[0]);
		check8("ch18", b, w[1]);
		check8("ch19", c, w[2]);
		check8("ch20", d, w[3]);
	endtask
	task automatic pulses(input int k, input int n);
		repeat (n) begin
			@(posedge clk);
			if (k == 0) fe <= 1'b1;
			else if (k == 1) sl <= 1'b1;
			else ce <= 1'b1;
		end
		@(posedge clk);
		{fe, sl, ce} <= 3'h0;
	endtask
	// Marker rises on a quiet cycle right after the strobe that enters t
	task automatic cap(input logic [7:0] t);
		int i;
		for (i = 0; i < 2000; i++) begin
			@(posedge clk);
			if (stb && pos == t - 8'h01) break;
		end
		if (i == 2000) begin
			fails++;
			final_report();
		end
		mk <= 1'b1;
		@(posedge clk);
		check8("idle", 8'h02, {6'h00, so, sen});
		@(posedge clk);
		mk <= 1'b0;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		check_words(8'hFF, 8'h00, 8'h00, 8'h00);
		@(posedge clk);
		nb <= 8'hC5;
		nv <= 1'b1;
		@(posedge clk);
		nv <= 1'b0;
		check_words(8'hC5, 8'h00, 8'h00, 8'h00);
		{fll, mll, remote_alarm, ts16, ext} <= 5'h1F;
		check_words(8'hC5, 8'hCE, 8'h00, 8'h00);
		{fll, mll, remote_alarm, ts16, ext} <= 5'h00;
		pulses(1, 1);
		check_words(8'hC5, 8'h10, 8'h00, 8'h00);
		pulses(1, 2);
		pulses(0, 15);
		check_words(8'hC5, 8'h10, 8'h00, 8'h00);
		pulses(0, 1);
		pulses(0, 16);
		check_words(8'hC5, 8'h30, 8'h00, 8'h00);
		repeat (1500) @(posedge clk);
		check_words(8'hC5, 8'h10, 8'h00, 8'h00);
		pulses(2, 3);
		check_words(8'hC5, 8'h10, 8'h00, 8'h03);
		pulses(2, 254);
		check_words(8'hC5, 8'h10, 8'h00, 8'h01);
		mt <= 1'b1;
		repeat (4200) @(posedge clk);
		check_words(8'hC5, 8'h10, 8'h00, 8'h00);
		cap(8'h60);
		check_words(8'hC5, 8'h10, 8'h60, 8'h00);
		cap(8'hE5);
		check_words(8'hC5, 8'h10, 8'hE5, 8'h00);
		check8("msb", 8'h00, {7'h00, fmsb});
		cap(8'h1B);
		check_words(8'hC5, 8'h10, 8'h1B, 8'h00);
		check8("msb", 8'h01, {7'h00, fmsb});
		final_report();
	end
endmodule // e1s_status_words_tb
